// ---- rtl/ach_pkg.sv ----
// constants for the answer-to-reset content composer
// assumes a single pclk domain and an apb master with 32-bit data
package ach_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ACH_CTRL_OFF = 8'h00;
  localparam logic [7:0] ACH_STAT_OFF = 8'h04;
  localparam logic [7:0] ACH_TA1_OFF = 8'h08;
  localparam logic [7:0] ACH_TA3_OFF = 8'h0c;
  localparam logic [7:0] ACH_TB3_OFF = 8'h10;
  localparam logic [7:0] ACH_HIST_OFF = 8'h14;
  localparam logic [7:0] ACH_DIV_OFF = 8'h18;
  // ==========================================================
  // field positions
  localparam int ACH_CTRL_START_BIT = 0;
  localparam int ACH_STAT_BUSY_BIT = 0;
  localparam int ACH_STAT_DONE_BIT = 1;
  // ==========================================================
  // reset values
  localparam logic [7:0] ACH_TA1_RST = 8'h95;
  localparam logic [7:0] ACH_TA3_RST = 8'h03;
  localparam logic [7:0] ACH_TB3_RST = 8'h00;
  localparam logic [31:0] ACH_HIST_RST = 32'h00_00_00_a0;
  // ==========================================================
  // fixed byte values, codes, lengths and indices of the answer-to-reset, plus the fifo depth
  localparam logic [7:0] ACH_TS = 8'h3b;
  localparam logic [3:0] ACH_HIST_LEN = 4'h7;
  localparam logic [3:0] ACH_T0_IND = 4'h9;
  localparam logic [7:0] ACH_TD1 = 8'h80;
  localparam logic [7:0] ACH_TD2 = 8'h3f;
  localparam logic [7:0] ACH_CAT_IND = 8'h80;
  localparam logic [7:0] ACH_TAG_SVC = 8'h31;
  localparam logic [7:0] ACH_TAG_CAP = 8'h73;
  localparam logic [7:0] ACH_GB_MASK = 8'hfc;
  localparam logic [3:0] ACH_FI_DEF = 4'h1;
  localparam logic [3:0] ACH_DI_DEF = 4'h1;
  localparam logic [3:0] ACH_FI_512 = 4'h9;
  localparam logic [3:0] ACH_DI_64 = 4'h7;
  localparam logic [4:0] ACH_NBYTES = 5'd15;
  localparam logic [4:0] ACH_IDX_TCK = 5'd14;
  localparam int ACH_FIFO_DEPTH = 4;
endpackage

// ---- rtl/ach_content.sv ----
// answer-to-reset content composer with apb registers and an output fifo
// assumes apb master on pclk; the byte stream is framed by logic downstream
// ==========================================================
// small fifo with valid/ready on both sides
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
module ach_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("fifo depth must be a power of two of at least 2");
    end
  end

  // handshakes: full and empty come straight from the count
  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_reg];

  // pointer and count update
  always_comb begin
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
endmodule

// ==========================================================
// top: composes the byte string and streams it out
// Behaviour
// - first historical byte is category 80
// - first data object has tag 31
// - second data object has tag 73
// - supports 372/1, 512/8 and 512/16
// - clock and baud factors sent in TA1
// - baud code 0111 means 64, only with 1001
// - every answer carries T=15 global bytes
// - TD2 names T=15, globals follow it
// - global byte zero means nothing extra
// - b8 with b5 means low-impedance drivers
// - b8 with b7 means inter-chip usb
// - b8 with b6 means contactless front-end
// - b8 with b4 means secure channel
// - b8, b4, b3 means secured command exchange
module ach_content #(
  parameter int FIFO_DEPTH = ach_pkg::ACH_FIFO_DEPTH
) (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // answer byte stream
  output logic atr_valid,
  input wire logic atr_ready,
  output logic [7:0] atr_data
);
  import ach_pkg::*;

  typedef enum logic [1:0] {
    ACH_IDLE = 2'b01,
    ACH_SEND = 2'b10
  } ach_state_e;

  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("fifo depth too small");
    end
  end

  // ==========================================================
  // helpers
  // baud divisor for a di code; 0 for codes not served
  function automatic logic [6:0] ach_di_div(input logic [3:0] di);
    case (di)
      4'h1: ach_di_div = 7'd1;
      4'h2: ach_di_div = 7'd2;
      4'h3: ach_di_div = 7'd4;
      4'h4: ach_di_div = 7'd8;
      4'h5: ach_di_div = 7'd16;
      4'h6: ach_di_div = 7'd32;
      ACH_DI_64: ach_di_div = 7'd64;
      default: ach_di_div = 7'd0;
    endcase
  endfunction

  // keep a factor pair legal; a bad pair falls back to 372/1
  function automatic logic [7:0] ach_fix_ta1(input logic [7:0] v);
    ach_fix_ta1 = v;
    if (v[3:0] == ACH_DI_64 && v[7:4] != ACH_FI_512) begin
      ach_fix_ta1 = {ACH_FI_DEF, ACH_DI_DEF};
    end else if (ach_di_div(v[3:0]) == 7'd0) begin
      ach_fix_ta1 = {ACH_FI_DEF, ACH_DI_DEF};
    end
  endfunction

  // global byte: only defined combinations leave the card
  function automatic logic [7:0] ach_fix_gb(input logic [7:0] v);
    logic [7:0] m;
    m = v & ACH_GB_MASK;
    if (!m[7]) begin
      m = 8'h00;
    end
    if (!m[3]) begin
      m[2] = 1'b0;
    end
    if (m[6:2] == 5'h00) begin
      m = 8'h00;
    end
    ach_fix_gb = m;
  endfunction

  // ==========================================================
  // register state
  logic [7:0] ta1_reg, ta1_next;
  logic [7:0] ta3_reg, ta3_next;
  logic [7:0] tb3_reg, tb3_next;
  logic [31:0] hist_reg, hist_next;
  logic done_reg, done_next;
  logic wr_en, rd_en, addr_ok;
  logic start_req;

  // ==========================================================
  // sender state
  ach_state_e state_reg, state_next;
  logic [4:0] idx_reg, idx_next;
  logic [7:0] tck_reg, tck_next;
  logic [7:0] s_ta1_reg, s_ta1_next;
  logic [7:0] s_ta3_reg, s_ta3_next;
  logic [7:0] s_tb3_reg, s_tb3_next;
  logic [31:0] s_hist_reg, s_hist_next;
  logic [7:0] cur_byte, ta1_fix;
  logic push_valid, push_ready, push_fire, last_byte;

  // ==========================================================
  // apb decode; zero wait states, unmapped address errors
  assign pready = 1'b1;
  assign ta1_fix = ach_fix_ta1(ta1_reg);
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  always_comb begin
    addr_ok = 1'b1;
    prdata = 32'h0000_0000;
    case (paddr)
      ACH_CTRL_OFF: prdata = 32'h0000_0000;
      ACH_STAT_OFF: begin
        prdata[ACH_STAT_BUSY_BIT] = (state_reg == ACH_SEND);
        prdata[ACH_STAT_DONE_BIT] = done_reg;
        prdata[12:8] = idx_reg;
      end
      ACH_TA1_OFF: prdata[7:0] = ta1_reg;
      ACH_TA3_OFF: prdata[7:0] = ta3_reg;
      ACH_TB3_OFF: prdata[7:0] = tb3_reg;
      ACH_HIST_OFF: prdata = hist_reg;
      ACH_DIV_OFF: prdata[6:0] = ach_di_div(ta1_fix[3:0]);
      default: addr_ok = 1'b0;
    endcase
    if (!rd_en) begin
      prdata = 32'h0000_0000;
    end
  end

  assign pslverr = psel && penable && !addr_ok;
  assign start_req = wr_en && paddr == ACH_CTRL_OFF && pwdata[ACH_CTRL_START_BIT];

  // register writes; done is set by the sender and set wins over clear
  always_comb begin
    ta1_next = ta1_reg;
    ta3_next = ta3_reg;
    tb3_next = tb3_reg;
    hist_next = hist_reg;
    done_next = done_reg;
    if (wr_en) begin
      case (paddr)
        ACH_TA1_OFF: ta1_next = pwdata[7:0];
        ACH_TA3_OFF: ta3_next = pwdata[7:0];
        ACH_TB3_OFF: tb3_next = pwdata[7:0];
        ACH_HIST_OFF: hist_next = pwdata;
        ACH_STAT_OFF: begin
          if (pwdata[ACH_STAT_DONE_BIT]) begin
            done_next = 1'b0;
          end
        end
        default: done_next = done_next;
      endcase
    end
    if (start_req && state_reg == ACH_IDLE) begin
      done_next = 1'b0;
    end
    if (push_fire && last_byte) begin
      done_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ta1_reg <= ACH_TA1_RST;
      ta3_reg <= ACH_TA3_RST;
      tb3_reg <= ACH_TB3_RST;
      hist_reg <= ACH_HIST_RST;
      done_reg <= 1'b0;
    end else begin
      ta1_reg <= ta1_next;
      ta3_reg <= ta3_next;
      tb3_reg <= tb3_next;
      hist_reg <= hist_next;
      done_reg <= done_next;
    end
  end

  // ==========================================================
  // byte selection from the snapshot taken at start
  always_comb begin
    case (idx_reg)
      5'd0: cur_byte = ACH_TS;
      5'd1: cur_byte = {ACH_T0_IND, ACH_HIST_LEN};
      5'd2: cur_byte = s_ta1_reg;
      5'd3: cur_byte = ACH_TD1;
      5'd4: cur_byte = ACH_TD2;
      5'd5: cur_byte = s_ta3_reg;
      5'd6: cur_byte = s_tb3_reg;
      5'd7: cur_byte = ACH_CAT_IND;
      5'd8: cur_byte = ACH_TAG_SVC;
      5'd9: cur_byte = s_hist_reg[7:0];
      5'd10: cur_byte = ACH_TAG_CAP;
      5'd11: cur_byte = s_hist_reg[15:8];
      5'd12: cur_byte = s_hist_reg[23:16];
      5'd13: cur_byte = s_hist_reg[31:24];
      ACH_IDX_TCK: cur_byte = tck_reg;
      default: cur_byte = 8'h00;
    endcase
  end

  assign push_valid = (state_reg == ACH_SEND);
  assign push_fire = push_valid && push_ready;
  assign last_byte = (idx_reg == ACH_NBYTES - 5'd1);

  // sequencer; the fifo stalls it when the stream is not drained
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    tck_next = tck_reg;
    s_ta1_next = s_ta1_reg;
    s_ta3_next = s_ta3_reg;
    s_tb3_next = s_tb3_reg;
    s_hist_next = s_hist_reg;
    case (state_reg)
      ACH_IDLE: begin
        if (start_req) begin
          // snapshot so register writes never tear an answer in flight
          state_next = ACH_SEND;
          idx_next = 5'd0;
          tck_next = 8'h00;
          s_ta1_next = ach_fix_ta1(ta1_reg);
          s_ta3_next = ta3_reg;
          s_tb3_next = ach_fix_gb(tb3_reg);
          s_hist_next = hist_reg;
        end
      end
      ACH_SEND: begin
        if (push_fire) begin
          // check byte covers everything after the initial character
          if (idx_reg != 5'd0) begin
            tck_next = tck_reg ^ cur_byte;
          end
          if (last_byte) begin
            state_next = ACH_IDLE;
          end else begin
            idx_next = idx_reg + 5'd1;
          end
        end
      end
      default: state_next = ACH_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ACH_IDLE;
      idx_reg <= 5'd0;
      tck_reg <= 8'h00;
      s_ta1_reg <= 8'h00;
      s_ta3_reg <= 8'h00;
      s_tb3_reg <= 8'h00;
      s_hist_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      tck_reg <= tck_next;
      s_ta1_reg <= s_ta1_next;
      s_ta3_reg <= s_ta3_next;
      s_tb3_reg <= s_tb3_next;
      s_hist_reg <= s_hist_next;
    end
  end

  // ==========================================================
  // output buffering
  ach_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(cur_byte),
    .out_valid(atr_valid),
    .out_ready(atr_ready),
    .out_data(atr_data)
  );
endmodule

// ---- tb/ach_content_checker.sv ----
// checker for the apb slave and answer byte stream of ach_content
// assumes it is bound to ach_content and sees only its ports
module ach_content_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // byte stream
  input wire logic atr_valid,
  input wire logic atr_ready,
  input wire logic [7:0] atr_data
);
  import ach_pkg::*;
  logic busy_reg, busy_next, take, go, live;
  logic [3:0] idx_reg, idx_next;
  logic [7:0] acc_reg, acc_next;
  assign take = atr_valid & atr_ready;
  assign go = psel & penable & pwrite & (paddr == ACH_CTRL_OFF) & pwdata[0];
  assign live = busy_reg & atr_valid;
  // ==========================================================
  // answer tracker: busy until the last byte is taken, so a start seen idle finds an empty fifo
  always_comb begin
    busy_next = busy_reg;
    idx_next = idx_reg;
    acc_next = acc_reg;
    if (go && !busy_reg) begin
      busy_next = 1'b1;
      idx_next = 4'h0;
      acc_next = 8'h00;
    end
    if (take && busy_reg) begin
      idx_next = idx_reg + 4'h1;
      if (idx_reg != 4'h0) acc_next = acc_reg ^ atr_data;
      if (idx_reg == 4'he) busy_next = 1'b0;
    end
  end
  // registers of the tracker
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      idx_reg <= 4'h0;
      acc_reg <= 8'h00;
    end else begin
      busy_reg <= busy_next;
      idx_reg <= idx_next;
      acc_reg <= acc_next;
    end
  end
  // ==========================================================
  // properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_start; go && !busy_reg && !atr_valid |-> ##2 atr_valid && atr_data == 8'h3b; endproperty
  a_start: assert property (p_start) else $error("answer did not start two edges after start");
  property p_hold; atr_valid && !atr_ready |=> atr_valid && $stable(atr_data); endproperty
  a_hold: assert property (p_hold) else $error("stalled byte changed or vanished");
  property p_ta1; live && idx_reg == 4'h2 |-> atr_data[3:0] inside {[4'h1:4'h7]}; endproperty
  a_ta1: assert property (p_ta1) else $error("baud code without a divisor");
  property p_di64; live && idx_reg == 4'h2 && atr_data[3:0] == 4'h7 |-> atr_data[7:4] == 4'h9; endproperty
  a_di64: assert property (p_di64) else $error("divisor 64 without clock code 1001");
  property p_t15; live && idx_reg == 4'h4 |-> atr_data == 8'h3f; endproperty
  a_t15: assert property (p_t15) else $error("second structural byte does not name 15");
  property p_cat; live && idx_reg == 4'h7 |-> atr_data == 8'h80; endproperty
  a_cat: assert property (p_cat) else $error("wrong category byte");
  property p_svc; live && idx_reg == 4'h8 |-> atr_data == 8'h31; endproperty
  a_svc: assert property (p_svc) else $error("wrong first object tag");
  property p_cap; live && idx_reg == 4'ha |-> atr_data == 8'h73; endproperty
  a_cap: assert property (p_cap) else $error("wrong second object tag");
  property p_gb; live && idx_reg == 4'h6 |-> atr_data[1:0] == 2'b00 && (atr_data[7] || atr_data == 8'h00); endproperty
  a_gb: assert property (p_gb) else $error("global byte reserved bits set");
  property p_gbc; live && idx_reg == 4'h6 && atr_data[7] |-> atr_data[6:3] != 4'h0 && (!atr_data[2] || atr_data[3]); endproperty
  a_gbc: assert property (p_gbc) else $error("global byte combination not listed");
  property p_tck; live && idx_reg == 4'he |-> atr_data == acc_reg; endproperty
  a_tck: assert property (p_tck) else $error("check byte wrong");
  property p_err; !(psel && penable) |-> !pslverr; endproperty
  a_err: assert property (p_err) else $error("error response outside an access phase");
endmodule
bind ach_content ach_content_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .atr_valid, .atr_ready, .atr_data);

// ---- tb/ach_term_model.sv ----
// terminal side model: takes every answer byte, stalling at random when slow
// assumes the valid/ready byte stream of ach_content on pclk
module ach_term_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // stall control
  input wire logic slow,
  // byte stream
  input wire logic atr_valid,
  output logic atr_ready,
  input wire logic [7:0] atr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  integer seed = 78;
  logic [7:0] got[$];
  logic t15_seen, pps_need, pps2_ok;
  // capabilities seen: low-impedance, usb, contactless, secure channel, secured exchange
  logic [4:0] caps;
  // ==========================================================
  // receiver: nothing is refused, unknown protocols and check byte included
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      atr_ready <= 1'b0;
      t15_seen <= 1'b0;
      pps_need <= 1'b0;
      pps2_ok <= 1'b0;
      caps <= 5'h00;
    end else begin
      if (atr_valid && atr_ready) begin
        got.push_back(atr_data);
        // any pair but the mandatory ones needs a selection exchange
        if (got.size() == 3) pps_need <= !(atr_data inside {8'h11, 8'h94, 8'h95});
        if (got.size() == 5) t15_seen <= atr_data[3:0] == 4'hf;
        if (got.size() == 5) pps2_ok <= atr_data[5];
        // b1 and b2 never read, so reserved codings cannot reject the card
        if (got.size() == 7) caps <= {5{atr_data[7]}} & {atr_data[4], atr_data[6], atr_data[5], atr_data[3],
          atr_data[3] & atr_data[2]};
      end
      atr_ready <= slow ? (($random(seed) & 3) == 0) : 1'b1;
    end
  end
endmodule

// ---- tb/tb_atr_content_handler.sv ----
// self-checking bench for ach_content with a terminal model on the stream
// assumes the checker is bound in and the model keeps every byte it takes
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb_atr_content_handler;
  timeunit 1ns;
  timeprecision 1ps;
  import ach_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, pready, pslverr, atr_valid, atr_ready, err;
  logic [7:0] paddr = 0, atr_data;
  logic [31:0] pwdata = 0, prdata, rd;
  int miscompares = 0, tests_run = 0, cycles = 0, seed = 78;
  logic [7:0] ta_t[5] = '{8'h17, 8'h18, 8'h96, 8'h11, 8'h94};
  logic [7:0] gb_t[5] = '{8'h84, 8'h90, 8'hc0, 8'ha0, 8'h8c};
  always #2 pclk = ~pclk;
  ach_content dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .atr_valid, .atr_ready, .atr_data);
  ach_term_model term_u (.pclk, .presetn, .slow, .atr_valid, .atr_ready, .atr_data);
  // ==========================================================
  // hang guard, well above twelve answers, eight of them stalled
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  task print_verdict;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one apb transfer, held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic rdy;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      rd = prdata;
      err = pslverr;
      rdy = pready;
    end while (rdy !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ==========================================================
  // expected sanitising of the configured bytes
  function automatic logic [7:0] san_ta1(logic [7:0] x);
    if (x[3:0] == 4'h0 || x[3:0] > 4'h7 || (x[3:0] == 4'h7 && x[7:4] != 4'h9)) return 8'h11;
    return x;
  endfunction
  function automatic logic [7:0] san_tb3(logic [7:0] x);
    logic [7:0] v;
    v = x & 8'hfc;
    if (!v[7]) v = 8'h00;
    if (!v[3]) v[2] = 1'b0;
    if (v == 8'h80) v = 8'h00;
    return v;
  endfunction
  // capabilities a terminal reads from a global byte, reserved bits ignored
  function automatic logic [4:0] caps_of(logic [7:0] g);
    if (!g[7]) return 5'h00;
    return {g[4], g[6], g[5], g[3], g[3] & g[2]};
  endfunction
  // one answer, with a refused second start while it is sent
  task answer(input logic [7:0] a1, input logic [7:0] gb, input logic [31:0] h, input logic s);
    logic [7:0] e[15];
    int n;
    e = '{8'h3b, 8'h97, san_ta1(a1), 8'h80, 8'h3f, 8'h03, san_tb3(gb), 8'h80, 8'h31, h[7:0], 8'h73,
      h[15:8], h[23:16], h[31:24], 8'h00};
    for (int i = 1; i < 14; i++) e[14] ^= e[i];
    slow <= s;
    apb(1'b1, ACH_TA1_OFF, {24'h0, a1});
    apb(1'b1, ACH_TB3_OFF, {24'h0, gb});
    apb(1'b1, ACH_HIST_OFF, h);
    term_u.got.delete();
    apb(1'b1, ACH_CTRL_OFF, 32'h1);
    apb(1'b1, ACH_CTRL_OFF, 32'h1);
    n = 0;
    while (term_u.got.size() < 15 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    repeat (20) @(posedge pclk);
    `CHK(term_u.got.size(), 15)
    for (int i = 0; i < 15; i++) `CHK(term_u.got[i], e[i])
    `CHK(term_u.t15_seen, 1'b1)
    `CHK(term_u.pps2_ok, 1'b1)
    `CHK(term_u.caps, caps_of(gb))
    `CHK(term_u.pps_need, !(san_ta1(a1) inside {8'h11, 8'h94, 8'h95}))
    apb(1'b0, ACH_STAT_OFF, 32'h0);
    `CHK(rd[1:0], 2'b10)
    $display("answer test done ta1 %h gb %h", a1, gb);
  endtask
  // ==========================================================
  // main sequence: resets, refusal, corner answers, random answers
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ACH_TA1_OFF, 32'h0);
    `CHK(rd, 32'h95)
    apb(1'b0, ACH_HIST_OFF, 32'h0);
    `CHK(rd, 32'ha0)
    apb(1'b0, 8'h40, 32'h0);
    `CHK(err, 1'b1)
    $display("register test done");
    answer(8'h97, 8'h00, 32'h1122_3344, 1'b0);
    apb(1'b0, ACH_DIV_OFF, 32'h0);
    `CHK(rd, 32'd64)
    for (int i = 0; i < 5; i++) answer(ta_t[i], gb_t[i], $random(seed), i[0]);
    repeat (6) answer(8'($random(seed)), 8'($random(seed)), $random(seed), 1'b1);
    apb(1'b1, ACH_STAT_OFF, 32'h2);
    apb(1'b0, ACH_STAT_OFF, 32'h0);
    `CHK(rd[1:0], 2'b00)
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ACH_TB3_OFF, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, ACH_TA1_OFF, 32'h0);
    `CHK(rd, 32'h95)
    $display("reset test done");
    print_verdict();
  end
endmodule
